// File: dv/dhg_drive_model.sv
`timescale 1ns/10ps
// **** drive read clock ****
module dhg_drive_model (
  input wire clk_i,
  input wire run_i,
  output reg rclk_o
);
  // fastest legal pace; stands low between frames
  // moves just after the rising edge so the block samples a settled level
  always @(posedge clk_i)
    rclk_o <= run_i & ~rclk_o;
endmodule

// File: dv/dhg_glue_props.sv
`timescale 1ns/10ps
// **** port checker ****
module dhg_glue_props (
  input wire CLK_SYS_I, RSTN_I, HOST_CARD_SELECT_I, SELECT_ADDRESS_ENABLE_I, QUALIFIED_CARD_SELECT_O,
  input wire WAIT_CLEAR_A_I, WAIT_CLEAR_B_I, WAIT_SET_I, WAIT_O, INDEX_PULSE_I, LATCHED_INDEX_CLEAR_I,
  input wire LATCHED_INDEX_OUT_O, DRIVE_TIMING_CLOCK_OUT_O, ADDRESS_MARK_DELAYED_OUT_O, READ_BYTE_STROBE_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  // a clear strobe from either host line
  sequence s_clr;
    $fell(WAIT_CLEAR_A_I) || $fell(WAIT_CLEAR_B_I);
  endsequence
  a_reset_levels: assert property (disable iff (1'h0) !RSTN_I |=> DRIVE_TIMING_CLOCK_OUT_O && !WAIT_O
    && !ADDRESS_MARK_DELAYED_OUT_O && !READ_BYTE_STROBE_O) else $error("reset levels");
  a_select_qual: assert property (1'h1 |=> QUALIFIED_CARD_SELECT_O ==
    ($past(HOST_CARD_SELECT_I) && $past(SELECT_ADDRESS_ENABLE_I))) else $error("select");
  a_wait_clear: assert property (s_clr ##1 !WAIT_SET_I |=> !WAIT_O) else $error("wait clear");
  a_wait_set: assert property (WAIT_SET_I && WAIT_CLEAR_A_I && WAIT_CLEAR_B_I |=> WAIT_O) else $error("wait set");
  a_index_late: assert property ($rose(INDEX_PULSE_I) |-> ##[1:2] LATCHED_INDEX_OUT_O) else $error("index");
  a_index_clear: assert property (LATCHED_INDEX_CLEAR_I && !INDEX_PULSE_I && !$past(INDEX_PULSE_I)
    |=> !LATCHED_INDEX_OUT_O) else $error("index clear");
  a_timing_toggle: assert property ($rose(DRIVE_TIMING_CLOCK_OUT_O) |=> !DRIVE_TIMING_CLOCK_OUT_O) else $error("tclk");
  a_strobe_single: assert property (READ_BYTE_STROBE_O |=> !READ_BYTE_STROBE_O) else $error("strobe");
endmodule
bind dhg_glue dhg_glue_props dhg_glue_props_i (.*);

// File: dv/dhg_glue_test.sv
`timescale 1ns/10ps
// **** bench ****
module dhg_glue_test;
  logic c, r, wa, wb, ws, en, cs, mk, ix, ic, run;
  wire rk, tk, qs, ao, li, wt, sb;
  wire [5:0] outs = {tk, qs, ao, li, wt, sb};
  int fail_count = 0, n_compared = 0, cyc_n = 0, g;
  // 50 ns system clock
  always #25 c = ~c;
  // cycle ceiling, far above the fifty or so cycles needed
  always @(posedge c)
    if (++cyc_n == 2000)
      print_verdict;
  dhg_drive_model dhg_drive_model_i (.clk_i(c), .run_i(run), .rclk_o(rk));
  dhg_glue dhg_glue_i (.CLK_SYS_I(c), .RSTN_I(r), .WAIT_CLEAR_A_I(wa), .WAIT_CLEAR_B_I(wb), .WAIT_SET_I(ws),
    .SELECT_ADDRESS_ENABLE_I(en), .HOST_CARD_SELECT_I(cs), .ADDRESS_MARK_DETECT_IN_I(mk), .READ_CLOCK_I(rk),
    .INDEX_PULSE_I(ix), .LATCHED_INDEX_CLEAR_I(ic), .DRIVE_TIMING_CLOCK_OUT_O(tk), .QUALIFIED_CARD_SELECT_O(qs),
    .ADDRESS_MARK_DELAYED_OUT_O(ao), .LATCHED_INDEX_OUT_O(li), .WAIT_O(wt), .READ_BYTE_STROBE_O(sb));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    fail_count += (seen !== exp);
    if (seen !== exp)
      $display("mismatch %0t %h %h", $time, seen, exp);
  endtask
  // waits n falling edges, then compares output k of outs
  task pr(input int n, input int k, input logic exp);
    repeat (n) @(negedge c);
    chk(outs[k], exp);
  endtask
  task print_verdict;
    fail_count += (cyc_n >= 2000);
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task t_sel;
    {en, cs} = 2'h1;
    pr(1, 4, 0);
    {en, cs} = 2'h3;
    pr(1, 4, 1);
  endtask
  // each clear line in turn drops a set wait
  task t_wait;
    ws = 1'h1;
    pr(1, 1, 1);
    {ws, wa} = 2'h0;
    pr(2, 1, 0);
    {ws, wa} = 2'h3;
    pr(1, 1, 1);
    {ws, wb} = 2'h0;
    pr(2, 1, 0);
    wb = 1'h1;
  endtask
  task t_idx;
    ix = 1'h1;
    pr(2, 2, 1);
    {ix, ic} = 2'h1;
    pr(2, 2, 0);
    ic = 1'h0;
  endtask
  // strobes must come eight read clock rises, sixteen cycles, apart
  task t_read;
    {mk, run} = 2'h3; // detector flags an A1 data byte
    repeat (2) @(negedge c);
    chk(ao, 1'h1);
    mk = 1'h0;
    for (g = 0; sb !== 1'h1 && g < 60; g++)
      @(negedge c);
    @(negedge c);
    for (g = 1; sb !== 1'h1 && g < 60; g++)
      @(negedge c);
    chk(g, 16);
    pr(0, 3, 0);
    run = 1'h0;
  endtask
  initial
  begin
    {c, r, ws, en, cs, mk, ix, ic, run} = 9'h0;
    {wa, wb} = 2'h3;
    pr(3, 5, 1);
    pr(0, 1, 0);
    r = 1'h1;
    t_sel;
    t_wait;
    t_idx;
    t_read;
    print_verdict;
  end
endmodule

// File: rtl/dhg_glue.v
// Overview of operation
// - falling wait-clear edge drops the wait latch
// - reset sets timing clock, clears wait, mark, strobe
// - select enable low blocks any card select
// - card select is host select and enable
// - timing clock output feeds the drives
// - read clock sampling produces delayed address mark
// - index clear drops latched index until next pulse
// - latched index is index one clock late
// - wait during internal access or unaccepted write
// - one read strobe per byte, framed by mark
`timescale 1ns/10ps
`include "dhg_map.vh"

module dhg_glue #(
  parameter TCLK_HALF = `DHG_TCLK_HALF
)(
  input wire CLK_SYS_I,
  input wire RSTN_I,
  input wire WAIT_CLEAR_A_I,
  input wire WAIT_CLEAR_B_I,
  input wire WAIT_SET_I,
  input wire SELECT_ADDRESS_ENABLE_I,
  input wire HOST_CARD_SELECT_I,
  input wire ADDRESS_MARK_DETECT_IN_I,
  input wire READ_CLOCK_I,
  input wire INDEX_PULSE_I,
  input wire LATCHED_INDEX_CLEAR_I,
  output reg DRIVE_TIMING_CLOCK_OUT_O,
  output reg QUALIFIED_CARD_SELECT_O,
  output reg ADDRESS_MARK_DELAYED_OUT_O,
  output reg LATCHED_INDEX_OUT_O,
  output reg WAIT_O,
  output reg READ_BYTE_STROBE_O
);

  // ************************************************************
  // edge history of inputs
  // ************************************************************
  // number of host lines that may clear the wait latch
  localparam CLR_LINES = 2;
  // framing states: hunting for a mark, or counting bits of a byte
  localparam FR_HUNT = 1'b0;
  localparam FR_BYTE = 1'b1;

  // edge detection, divider, bit count and framing state, and the derived one-cycle events
  wire [CLR_LINES-1:0] wcl_in;
  reg [CLR_LINES-1:0] wcl_q;
  reg rclk_q;
  reg index_q;
  reg [`DHG_TCLK_CNT_W-1:0] tclk_cnt;
  reg [`DHG_BIT_CNT_W-1:0] bit_cnt;
  reg frame_state;
  reg next_frame_state;
  wire [CLR_LINES-1:0] wcl_fell;
  wire wcl_fall;
  wire rclk_rise;
  wire index_rise;
  genvar n;

  // both clear lines share one detector shape, so they are indexed
  assign wcl_in = {WAIT_CLEAR_B_I, WAIT_CLEAR_A_I};
  assign wcl_fall = |wcl_fell;
  assign rclk_rise = READ_CLOCK_I & ~rclk_q;
  assign index_rise = INDEX_PULSE_I & ~index_q;

  // history resets to the idle high level so no false fall follows reset
  generate
    for (n = 0; n < CLR_LINES; n = n + 1)
    begin : g_clr
      always @(posedge CLK_SYS_I)
      begin
        if (!RSTN_I)
          wcl_q[n] <= 1'b1;
        else
          wcl_q[n] <= wcl_in[n];
      end
      assign wcl_fell[n] = wcl_q[n] & ~wcl_in[n];
    end
  endgenerate

  // previous values; inputs are synchronous so one stage suffices
  // limitation: a read clock faster than half the system clock is missed
  always @(posedge CLK_SYS_I)
  begin
    if (!RSTN_I)
    begin
      rclk_q <= 1'b0;
      index_q <= 1'b0;
    end
    else
    begin
      rclk_q <= READ_CLOCK_I;
      index_q <= INDEX_PULSE_I;
    end
  end

  // ************************************************************
  // host side: card select and wait latch
  // ************************************************************
  // card select is registered so the output is glitch free
  always @(posedge CLK_SYS_I)
  begin
    if (!RSTN_I)
      QUALIFIED_CARD_SELECT_O <= 1'b0;
    else
      QUALIFIED_CARD_SELECT_O <= HOST_CARD_SELECT_I & SELECT_ADDRESS_ENABLE_I;
  end

  // wait set by busy request; a clear edge wins so the host is never stuck
  always @(posedge CLK_SYS_I)
  begin
    if (!RSTN_I)
      WAIT_O <= `DHG_WAIT_RST;
    else if (wcl_fall)
      WAIT_O <= 1'b0;
    else if (WAIT_SET_I)
      WAIT_O <= 1'b1;
  end

  // ************************************************************
  // drive side: timing clock, index, address mark, byte strobe
  // ************************************************************
  // timing clock divided down from the system clock
  always @(posedge CLK_SYS_I)
  begin
    if (!RSTN_I)
    begin
      tclk_cnt <= {`DHG_TCLK_CNT_W{1'b0}};
      DRIVE_TIMING_CLOCK_OUT_O <= `DHG_TCLK_RST;
    end
    else if (tclk_cnt >= TCLK_HALF[`DHG_TCLK_CNT_W-1:0] - 4'h1)
    begin
      tclk_cnt <= {`DHG_TCLK_CNT_W{1'b0}};
      DRIVE_TIMING_CLOCK_OUT_O <= ~DRIVE_TIMING_CLOCK_OUT_O;
    end
    else
      tclk_cnt <= tclk_cnt + 4'h1;
  end

  // latched index: a new pulse beats the clear in the same cycle
  always @(posedge CLK_SYS_I)
  begin
    if (!RSTN_I)
      LATCHED_INDEX_OUT_O <= 1'b0;
    else if (index_rise)
      LATCHED_INDEX_OUT_O <= 1'b1;
    else if (LATCHED_INDEX_CLEAR_I)
      LATCHED_INDEX_OUT_O <= 1'b0;
  end

  // mark is resampled on each read clock rise, one bit time late
  always @(posedge CLK_SYS_I)
  begin
    if (!RSTN_I)
      ADDRESS_MARK_DELAYED_OUT_O <= 1'b0;
    else if (rclk_rise)
      ADDRESS_MARK_DELAYED_OUT_O <= ADDRESS_MARK_DETECT_IN_I;
  end

  // ************************************************************
  // byte framing of the read stream
  // ************************************************************
  // read bits before the first mark carry no byte boundary, so the
  // framer hunts until the detector flags a mark, then stays framed;
  // a later mark only restarts the bit count inside the byte
  always @*
  begin
    next_frame_state = frame_state;
    case (frame_state)
      FR_HUNT:
        if (rclk_rise && ADDRESS_MARK_DETECT_IN_I)
          next_frame_state = FR_BYTE;
      FR_BYTE:
        next_frame_state = FR_BYTE;
      default:
        next_frame_state = FR_HUNT;
    endcase
  end

  // framing state register
  always @(posedge CLK_SYS_I)
  begin
    if (!RSTN_I)
      frame_state <= FR_HUNT;
    else
      frame_state <= next_frame_state;
  end

  // bit counter and strobe; strobe lasts one system clock
  // trade-off: the strobe marks the byte end late by the detect cycle,
  // which keeps it aligned with the registered mark output
  always @(posedge CLK_SYS_I)
  begin
    if (!RSTN_I)
    begin
      bit_cnt <= {`DHG_BIT_CNT_W{1'b0}};
      READ_BYTE_STROBE_O <= 1'b0;
    end
    else
    begin
      READ_BYTE_STROBE_O <= 1'b0;
      if (rclk_rise)
      begin
        if (ADDRESS_MARK_DETECT_IN_I)
          bit_cnt <= {`DHG_BIT_CNT_W{1'b0}};
        else if (frame_state == FR_BYTE)
        begin
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == `DHG_BIT_LAST)
            READ_BYTE_STROBE_O <= 1'b1;
        end
      end
    end
  end

endmodule

// File: shared/dhg_map.vh
`ifndef DHG_MAP_VH
`define DHG_MAP_VH
// read byte framing: bits per byte on the read stream
`define DHG_BITS_PER_BYTE 8
// width of the bit counter inside a byte
`define DHG_BIT_CNT_W 3
// last bit index within a byte
`define DHG_BIT_LAST 3'h7
// timing clock divider half period in system clocks
`define DHG_TCLK_HALF 4'h1
// divider counter width
`define DHG_TCLK_CNT_W 4
// reset levels
`define DHG_TCLK_RST 1'b1
`define DHG_WAIT_RST 1'b0
// delay of the address mark output in read bit times
`define DHG_AM_DELAY 1
`endif
